/* shared/des_pkg.sv */
package des_pkg;

    // register byte offsets
    localparam logic [7:0] DES_STATUS_OFS = 8'h28;
    localparam logic [7:0] DES_ENABLE_OFS = 8'h38;
    localparam logic [7:0] DES_CTRL_OFS = 8'h80;
    localparam logic [31:0] DES_RESET_VALUE = 32'h0000_0000;

    // status word layout
    localparam int DES_FLAG_W = 17;
    localparam int BIT_TX_DONE = 0;
    localparam int BIT_TX_STOPPED = 1;
    localparam int BIT_TX_DESC_MISSING = 2;
    localparam int BIT_TX_JABBER = 3;
    localparam int BIT_TX_UNDERFLOW = 5;
    localparam int BIT_RX_DONE = 6;
    localparam int BIT_RX_DESC_MISSING = 7;
    localparam int BIT_RX_STOPPED = 8;
    localparam int BIT_RX_WATCHDOG = 9;
    localparam int BIT_GP_TIMER = 11;
    localparam int BIT_BUS_FAULT = 13;
    localparam int BIT_ABNORMAL = 15;
    localparam int BIT_NORMAL = 16;
    localparam int RX_STATE_LSB = 17;
    localparam int TX_STATE_LSB = 20;
    localparam int BUS_ERR_LSB = 23;

    localparam logic [16:0] NORMAL_SRC_MASK = 17'h0_0045;
    localparam logic [16:0] ABNORMAL_SRC_MASK = 17'h0_2BAA;
    localparam logic [16:0] FLAG_USED_MASK = 17'h1_ABEF;

    // transmit state codes
    localparam logic [2:0] TX_STOPPED = 3'h0;
    localparam logic [2:0] TX_READ_DESC = 3'h1;
    localparam logic [2:0] TX_SENDING = 3'h2;
    localparam logic [2:0] TX_FIFO_FILL = 3'h3;
    localparam logic [2:0] TX_SUSPENDED = 3'h6;
    localparam logic [2:0] TX_WRITE_DESC = 3'h7;

    // receive state codes
    localparam logic [2:0] RX_STOPPED = 3'h0;
    localparam logic [2:0] RX_READ_DESC = 3'h1;
    localparam logic [2:0] RX_CHECK_FRAME = 3'h2;
    localparam logic [2:0] RX_WAIT_DATA = 3'h3;
    localparam logic [2:0] RX_SUSPENDED = 3'h4;
    localparam logic [2:0] RX_WRITE_DESC = 3'h5;
    localparam logic [2:0] RX_FLUSH = 3'h6;
    localparam logic [2:0] RX_DRAIN = 3'h7;

    // bus error kinds
    localparam logic [2:0] BUS_ERR_PARITY = 3'h0;
    localparam logic [2:0] BUS_ERR_MASTER_ABORT = 3'h1;
    localparam logic [2:0] BUS_ERR_TARGET_ABORT = 3'h2;

    // transmit descriptor status word marks
    localparam int TDES_UNDERFLOW_BIT = 1;
    localparam int TDES_JABBER_BIT = 14;

    // own control register
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_BUS_HALT_BIT = 1;

    typedef enum logic [1:0] {
        DES_BUS_IDLE = 2'b01,
        DES_BUS_ACK = 2'b10
    } des_bus_state_e;

endpackage

/* logic/des_flag_bank.sv */
`timescale 1ns/1ps
module des_flag_bank #(
    parameter int N = 17
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [N-1:0] set_in,
    input wire logic [N-1:0] clr_in,
    output logic [N-1:0] flag_q
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // an event in the clearing cycle keeps the flag set
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_q[i] <= 1'b0;
                end else if (set_in[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (clr_in[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

/* logic/des_state_monitor.sv */
`timescale 1ns/1ps
module des_state_monitor #(
    parameter int W = 3,
    parameter logic [W-1:0] STOP_CODE = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] state_in,
    output logic [W-1:0] state_q,
    output logic entered_stop
);
    // the reset value equals the stop code, so reset raises no entry pulse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= STOP_CODE;
        end else begin
            state_q <= state_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            entered_stop <= 1'b0;
        end else begin
            entered_stop <= (state_in == STOP_CODE) && (state_q != STOP_CODE);
        end
    end
endmodule

/* logic/des_status_top.sv */
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - bus error cause kept in bits 25:23
// - transmit state code shown in bits 22:20
// - receive state code shown in bits 19:17
// - normal summary set from bits 0,2,6
// - abnormal summary set from abnormal event bits
// - flags latch high, software writes 1 clearing
// - fatal bus fault flags and halts bus mastering
// - general timer expiry sets bit 11
// - receive watchdog expiry sets bit 9
// - receive entering stopped sets bit 8
// - missing receive descriptor flags and suspends receive
// - receive resumes on poll or new frame unless bus mastering is halted
// - each finished received frame sets bit 6
// - underflow flags, suspends transmit, marks descriptor bit1
// - jabber flags, stops transmit, marks descriptor bit14
// - missing transmit descriptor flags and suspends transmit
// - transmit entering stopped sets bit 1
// - transmit done flags only with completion request
// - interrupt needs event enable and group enable
module des_status_top
    import des_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // dma engine events, one-cycle pulses
    input wire logic tx_frame_done_evt,
    input wire logic tx_first_desc_ioc,
    input wire logic tx_underflow_evt,
    input wire logic tx_jabber_evt,
    input wire logic tx_desc_missing_evt,
    input wire logic rx_frame_done_evt,
    input wire logic rx_desc_missing_evt,
    input wire logic rx_poll_demand,
    input wire logic rx_frame_seen,
    input wire logic rx_watchdog_evt,
    input wire logic general_timer_evt,
    input wire logic bus_fault_evt,
    input wire logic [2:0] bus_fault_kind,
    // dma engine state codes
    input wire logic [2:0] tx_state_code,
    input wire logic [2:0] rx_state_code,
    // commands back to the dma engines
    output logic tx_suspend_req,
    output logic tx_stop_req,
    output logic rx_suspend_req,
    output logic rx_resume_req,
    output logic tx_desc_mark,
    output logic [31:0] tx_desc_status_set,
    output logic bus_master_halt,
    output logic soft_reset_pulse,
    output logic irq_request
);

    des_bus_state_e bus_state_reg;
    logic [31:0] enable_reg;
    logic [DES_FLAG_W-1:0] flag_set;
    logic [DES_FLAG_W-1:0] flag_clr;
    logic [DES_FLAG_W-1:0] flag_q;
    logic [2:0] bus_error_kind_reg;
    logic [2:0] tx_state_q;
    logic [2:0] rx_state_q;
    logic tx_entered_stop;
    logic rx_entered_stop;
    logic [31:0] be_mask;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic write_take;
    logic status_write;
    logic ctrl_write;
    logic soft_reset_now;
    logic [DES_FLAG_W-1:0] flag_keep;
    logic normal_src;
    logic abnormal_src;
    logic normal_pending;
    logic abnormal_pending;

    function automatic logic [31:0] expand_be(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction

    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // ---------------- bus slave ----------------
    // every access costs one wait cycle so read data come from a flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= DES_BUS_IDLE;
        end else begin
            case (bus_state_reg)
                DES_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= DES_BUS_ACK;
                    end
                end
                DES_BUS_ACK: begin
                    bus_state_reg <= DES_BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= DES_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((bus_state_reg == DES_BUS_IDLE) &&
                                 (avs_read || avs_write));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if ((bus_state_reg == DES_BUS_IDLE) && avs_read) begin
            if (reg_hit(avs_address, DES_STATUS_OFS)) begin
                avs_readdata <= status_word;
            end else if (reg_hit(avs_address, DES_ENABLE_OFS)) begin
                avs_readdata <= enable_reg;
            end else if (reg_hit(avs_address, DES_CTRL_OFS)) begin
                avs_readdata <= ctrl_word;
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // writes land at the edge where the master sees waitrequest low
    assign write_take = (bus_state_reg == DES_BUS_ACK) && avs_write;
    assign be_mask = expand_be(avs_byteenable);
    assign status_write = write_take && reg_hit(avs_address, DES_STATUS_OFS);
    assign ctrl_write = write_take && reg_hit(avs_address, DES_CTRL_OFS);
    assign soft_reset_now = ctrl_write &&
        avs_writedata[CTRL_SOFT_RESET_BIT] && be_mask[CTRL_SOFT_RESET_BIT];

    // enable bits follow the status layout; unused ones read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= DES_RESET_VALUE;
        end else if (write_take && reg_hit(avs_address, DES_ENABLE_OFS)) begin
            enable_reg <= (avs_writedata & be_mask) |
                          (enable_reg & ~be_mask);
            enable_reg[31:DES_FLAG_W] <= '0;
            enable_reg[DES_FLAG_W-1:0] <=
                ((avs_writedata[DES_FLAG_W-1:0] & be_mask[DES_FLAG_W-1:0]) |
                 (enable_reg[DES_FLAG_W-1:0] & ~be_mask[DES_FLAG_W-1:0])) &
                FLAG_USED_MASK;
        end
    end

    // ---------------- state codes ----------------
    des_state_monitor #(
        .W(3),
        .STOP_CODE(TX_STOPPED)
    ) u_tx_state (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .state_in(tx_state_code),
        .state_q(tx_state_q),
        .entered_stop(tx_entered_stop)
    );

    // rx wait-for-data arrives as RX_WAIT_DATA and is shown unchanged
    des_state_monitor #(
        .W(3),
        .STOP_CODE(RX_STOPPED)
    ) u_rx_state (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .state_in(rx_state_code),
        .state_q(rx_state_q),
        .entered_stop(rx_entered_stop)
    );

    // ---------------- sticky flags ----------------
    always_comb begin
        flag_set = '0;
        flag_set[BIT_TX_DONE] = tx_frame_done_evt && tx_first_desc_ioc;
        flag_set[BIT_TX_STOPPED] = tx_entered_stop;
        flag_set[BIT_TX_DESC_MISSING] = tx_desc_missing_evt;
        flag_set[BIT_TX_JABBER] = tx_jabber_evt;
        flag_set[BIT_TX_UNDERFLOW] = tx_underflow_evt;
        flag_set[BIT_RX_DONE] = rx_frame_done_evt;
        flag_set[BIT_RX_DESC_MISSING] = rx_desc_missing_evt;
        flag_set[BIT_RX_STOPPED] = rx_entered_stop;
        flag_set[BIT_RX_WATCHDOG] = rx_watchdog_evt;
        flag_set[BIT_GP_TIMER] = general_timer_evt;
        flag_set[BIT_BUS_FAULT] = bus_fault_evt;
        flag_set[BIT_NORMAL] = normal_src;
        flag_set[BIT_ABNORMAL] = abnormal_src;
    end

    // write-one-clear; soft reset wipes every flag
    // reserved bits ignore writes so they keep reading zero
    always_comb begin
        flag_clr = {DES_FLAG_W{soft_reset_now}};
        if (status_write) begin
            flag_clr = flag_clr |
                (avs_writedata[DES_FLAG_W-1:0] & be_mask[DES_FLAG_W-1:0] &
                 FLAG_USED_MASK);
        end
    end

    // summaries look at sources that survive this edge, so a single write
    // of ones clears a summary together with its sources
    always_comb begin
        flag_keep = flag_q & ~flag_clr;
        normal_src = |(flag_keep & NORMAL_SRC_MASK);
        abnormal_src = |(flag_keep & ABNORMAL_SRC_MASK);
    end

    des_flag_bank #(
        .N(DES_FLAG_W)
    ) u_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set_in(flag_set),
        .clr_in(flag_clr),
        .flag_q(flag_q)
    );

    // cause only meaningful while the fault flag is up
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_error_kind_reg <= BUS_ERR_PARITY;
        end else if (bus_fault_evt) begin
            bus_error_kind_reg <= bus_fault_kind;
        end
    end

    always_comb begin
        // bits 31:26 are reserved and read zero
        status_word = 32'h0000_0000;
        status_word[DES_FLAG_W-1:0] = flag_q & FLAG_USED_MASK;
        status_word[RX_STATE_LSB +: 3] = rx_state_q;
        status_word[TX_STATE_LSB +: 3] = tx_state_q;
        status_word[BUS_ERR_LSB +: 3] = bus_error_kind_reg;
    end

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_BUS_HALT_BIT] = bus_master_halt;
    end

    // ---------------- bus fault halt ----------------
    // halt holds until software reset; a new fault in that cycle still halts
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_master_halt <= 1'b0;
        end else if (bus_fault_evt) begin
            bus_master_halt <= 1'b1;
        end else if (soft_reset_now) begin
            bus_master_halt <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_reset_now;
        end
    end

    // ---------------- commands to the dma engines ----------------
    // command pulses go out one edge after the event behind them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_suspend_req <= 1'b0;
            tx_stop_req <= 1'b0;
        end else begin
            tx_suspend_req <= tx_underflow_evt || tx_desc_missing_evt;
            tx_stop_req <= tx_jabber_evt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_desc_mark <= 1'b0;
            tx_desc_status_set <= 32'h0000_0000;
        end else begin
            tx_desc_mark <= tx_underflow_evt || tx_jabber_evt;
            tx_desc_status_set <= 32'h0000_0000;
            tx_desc_status_set[TDES_UNDERFLOW_BIT] <= tx_underflow_evt;
            tx_desc_status_set[TDES_JABBER_BIT] <= tx_jabber_evt;
        end
    end

    // a suspended receiver restarts on a poll or on a recognised frame
    // a halted engine waits for the software reset before resuming
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_suspend_req <= 1'b0;
            rx_resume_req <= 1'b0;
        end else begin
            rx_suspend_req <= rx_desc_missing_evt;
            rx_resume_req <= (rx_state_q == RX_SUSPENDED) &&
                             (rx_poll_demand || rx_frame_seen) &&
                             !bus_master_halt;
        end
    end

    // ---------------- interrupt request ----------------
    // an event is pending when flagged and individually enabled
    always_comb begin
        normal_pending = |(flag_q & enable_reg[DES_FLAG_W-1:0] &
                           NORMAL_SRC_MASK);
        abnormal_pending = |(flag_q & enable_reg[DES_FLAG_W-1:0] &
                             ABNORMAL_SRC_MASK);
    end

    // group enable gates each event enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= (enable_reg[BIT_NORMAL] && normal_pending) ||
                           (enable_reg[BIT_ABNORMAL] && abnormal_pending);
        end
    end

endmodule

/* tb/des_status_top_sva.sv */
`timescale 1ns/1ps
module des_status_sva
    import des_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic tx_underflow_evt,
    input wire logic tx_jabber_evt,
    input wire logic tx_desc_missing_evt,
    input wire logic rx_desc_missing_evt,
    input wire logic bus_fault_evt,
    input wire logic tx_suspend_req,
    input wire logic tx_stop_req,
    input wire logic rx_suspend_req,
    input wire logic tx_desc_mark,
    input wire logic [31:0] tx_desc_status_set,
    input wire logic bus_master_halt,
    input wire logic soft_reset_pulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_uf_marks;
        tx_suspend_req && tx_desc_mark
            && tx_desc_status_set[TDES_UNDERFLOW_BIT];
    endsequence
    sequence s_jab_marks;
        tx_stop_req && tx_desc_mark && tx_desc_status_set[TDES_JABBER_BIT];
    endsequence

    a_underflow_marks: assert property (tx_underflow_evt |=> s_uf_marks)
        else $error("underflow gave no suspend or descriptor mark");
    a_jabber_stop: assert property (tx_jabber_evt |=> s_jab_marks)
        else $error("jabber gave no stop or descriptor mark");
    a_txdesc_suspend: assert property (tx_desc_missing_evt |=> tx_suspend_req)
        else $error("missing tx descriptor did not suspend");
    a_rxdesc_suspend: assert property (rx_desc_missing_evt |=> rx_suspend_req)
        else $error("missing rx descriptor did not suspend");
    a_fault_halt: assert property (bus_fault_evt |=> bus_master_halt)
        else $error("bus fault did not halt mastering");
    // halt may only drop because of a soft reset
    a_halt_sticky: assert property ($fell(bus_master_halt) |->
        soft_reset_pulse || $past(soft_reset_pulse)
            || $past(soft_reset_pulse, 2))
        else $error("bus halt dropped without soft reset");
    a_soft_reset: assert property ((avs_write && !avs_waitrequest
        && avs_address == DES_CTRL_OFS && avs_byteenable[0]
        && avs_writedata[CTRL_SOFT_RESET_BIT]) |-> ##[0:2] soft_reset_pulse)
        else $error("soft reset write gave no pulse");
    a_answer_next: assert property ($rose(avs_read || avs_write)
        |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer lasted more than one cycle");
endmodule

bind des_status_top des_status_sva u_sva (.sys_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
    .tx_underflow_evt, .tx_jabber_evt, .tx_desc_missing_evt,
    .rx_desc_missing_evt, .bus_fault_evt, .tx_suspend_req, .tx_stop_req,
    .rx_suspend_req, .tx_desc_mark, .tx_desc_status_set, .bus_master_halt,
    .soft_reset_pulse);

/* tb/des_status_top_tb.sv */
`timescale 1ns/1ps
module des_status_top_tb import des_pkg::*;;
    typedef struct packed {
        logic [8:0] ev;
        logic ioc;
        logic [2:0] kind;
        logic [16:0] flags;
    } des_row_s;
    // ev bits: txdone uf jab txdesc rxdone rxdesc wdog timer fault
    des_row_s rows [13] = '{'{9'h001, 1'b1, 3'h0, 17'h0_0001},
        '{9'h001, 1'b0, 3'h0, 17'h0_0000}, '{9'h002, 1'b0, 3'h0, 17'h0_0020},
        '{9'h004, 1'b0, 3'h0, 17'h0_0008}, '{9'h008, 1'b0, 3'h0, 17'h0_0004},
        '{9'h010, 1'b0, 3'h0, 17'h0_0040}, '{9'h020, 1'b0, 3'h0, 17'h0_0080},
        '{9'h040, 1'b0, 3'h0, 17'h0_0200}, '{9'h080, 1'b0, 3'h0, 17'h0_0800},
        '{9'h100, 1'b0, 3'h0, 17'h0_2000}, '{9'h100, 1'b0, 3'h1, 17'h0_2000},
        '{9'h100, 1'b0, 3'h2, 17'h0_2000}, '{9'h0A0, 1'b0, 3'h0, 17'h0_0880}};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [8:0] ev = 9'h000;
    logic ioc = 1'b0;
    logic [1:0] rxw = 2'h0;
    logic [2:0] kind = 3'h0;
    logic [2:0] txs = 3'h0;
    logic [2:0] rxs = 3'h0;
    logic [31:0] avs_readdata, tx_desc_status_set, rd, m;
    logic avs_waitrequest, tx_suspend_req, tx_stop_req, rx_suspend_req;
    logic rx_resume_req, tx_desc_mark, bus_master_halt, soft_reset_pulse;
    logic irq_request, seen;
    int miscompares = 0;
    int n_compared = 0;
    int i;

    always #2.5 sys_clk = ~sys_clk;

    des_status_top uut (.sys_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .tx_frame_done_evt(ev[0]), .tx_first_desc_ioc(ioc),
        .tx_underflow_evt(ev[1]), .tx_jabber_evt(ev[2]),
        .tx_desc_missing_evt(ev[3]), .rx_frame_done_evt(ev[4]),
        .rx_desc_missing_evt(ev[5]), .rx_poll_demand(rxw[0]),
        .rx_frame_seen(rxw[1]), .rx_watchdog_evt(ev[6]),
        .general_timer_evt(ev[7]), .bus_fault_evt(ev[8]),
        .bus_fault_kind(kind), .tx_state_code(txs), .rx_state_code(rxs),
        .tx_suspend_req, .tx_stop_req, .rx_suspend_req, .rx_resume_req,
        .tx_desc_mark, .tx_desc_status_set, .bus_master_halt,
        .soft_reset_pulse, .irq_request);

    task report_and_stop;
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e, input string what);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask

    // holds the request until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
             input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 50)
            miscompares++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task pulse(input logic [8:0] v);
        @(posedge sys_clk);
        ev <= v;
        @(posedge sys_clk);
        ev <= 9'h000;
        repeat (4) @(posedge sys_clk);
    endtask

    function automatic logic [16:0] summ(input logic [16:0] f);
        logic [16:0] s;
        s = f;
        if ((f & NORMAL_SRC_MASK) != 17'h0_0000)
            s[BIT_NORMAL] = 1'b1;
        if ((f & ABNORMAL_SRC_MASK) != 17'h0_0000)
            s[BIT_ABNORMAL] = 1'b1;
        return s;
    endfunction

    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        chk(32'(avs_waitrequest), 32'h0000_0001, "waitrequest in reset");
        rst_n <= 1'b1;
        bus(1'b0, DES_STATUS_OFS, 32'h0000_0000, 4'hF);
        chk(rd, DES_RESET_VALUE, "status after reset");
        txs <= TX_SENDING;
        rxs <= RX_CHECK_FRAME;
        for (i = 0; i < 13; i++) begin
            ioc <= rows[i].ioc;
            kind <= rows[i].kind;
            pulse(rows[i].ev);
            m = rows[i].ev[8] ? 32'hFFFF_FFFF : 32'hFC7F_FFFF;
            bus(1'b0, DES_STATUS_OFS, 32'h0000_0000, 4'hF);
            chk(rd & m, {6'h00, rows[i].kind, TX_SENDING, RX_CHECK_FRAME,
                summ(rows[i].flags)} & m, "event status");
            if (rows[i].ev[8]) begin
                chk(32'(bus_master_halt), 32'h0000_0001, "halt");
                bus(1'b1, DES_CTRL_OFS, 32'h0000_0001, 4'hF);
                repeat (3) @(posedge sys_clk);
                chk(32'(bus_master_halt), 32'h0000_0000, "unhalt");
            end
            bus(1'b1, DES_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
            bus(1'b0, DES_STATUS_OFS, 32'h0000_0000, 4'hF);
            chk({15'h0000, rd[16:0]}, 32'h0000_0000, "flags cleared");
        end
        for (i = 1; i < 8; i++) begin
            txs <= 3'(i); // step through state codes 1 to 7
            rxs <= 3'(i);
            repeat (2) @(posedge sys_clk);
            bus(1'b0, DES_STATUS_OFS, 32'h0000_0000, 4'hF);
            chk({26'h0, rd[22:17]}, {26'h0, 3'(i), 3'(i)}, "states");
        end
        txs <= TX_STOPPED;
        rxs <= RX_STOPPED;
        repeat (4) @(posedge sys_clk);
        bus(1'b0, DES_STATUS_OFS, 32'h0000_0000, 4'hF);
        chk(rd & 32'h007F_FFFF, 32'h0000_8102, "stop flags");
        // lane 1 only: clears 15:8; abnormal summary re-arms from bit 1
        ioc <= 1'b1;
        pulse(9'h081);
        bus(1'b1, DES_STATUS_OFS, 32'hFFFF_FFFF, 4'h2);
        bus(1'b0, DES_STATUS_OFS, 32'h0000_0000, 4'hF);
        chk(rd & 32'h007F_FFFF, 32'h0001_8003, "lane clear");
        bus(1'b1, DES_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
        for (i = 0; i < 2; i++) begin
            bus(1'b1, DES_ENABLE_OFS, i ? 32'h0000_0020 : 32'h0000_8020, 4'hF);
            pulse(9'h002);
            chk(32'(irq_request), 32'(i == 0), "irq");
            bus(1'b1, DES_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
        end
        rxs <= RX_SUSPENDED;
        for (i = 0; i < 2; i++) begin
            repeat (2) @(posedge sys_clk);
            rxw <= 2'(i + 1);
            @(posedge sys_clk);
            rxw <= 2'h0;
            seen = 1'b0;
            repeat (3) begin
                @(posedge sys_clk);
                seen = seen | rx_resume_req;
            end
            chk(32'(seen), 32'h0000_0001, "rx resume");
        end
        bus(1'b1, 8'h44, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 8'h44, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000, "unmapped read");
        pulse(9'h080);
        rst_n <= 1'b0;
        rxs <= RX_STOPPED;
        repeat (2) @(posedge sys_clk);
        chk(32'(avs_waitrequest), 32'h0000_0001, "waitrequest in reset");
        rst_n <= 1'b1;
        bus(1'b0, DES_STATUS_OFS, 32'h0000_0000, 4'hF);
        chk(rd, DES_RESET_VALUE, "status after second reset");
        report_and_stop();
    end
endmodule
